// *** dps_defs.svh ***
// Constants of the drive protection supervisor: offsets, fields, timing
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
// ==========================================================
// Register byte offsets
`define DPS_A_STALL_CTRL 8'h00
`define DPS_A_ACC_LVL    8'h04
`define DPS_A_ACC_LIM    8'h08
`define DPS_A_ACC_LVL2   8'h0c
`define DPS_A_ACC_LIM2   8'h10
`define DPS_A_DEC_LVL    8'h14
`define DPS_A_RUN_STALL  8'h18
`define DPS_A_MODE       8'h1c
`define DPS_A_BASE_FREQ  8'h20
`define DPS_A_OL_CFG     8'h24
`define DPS_A_PHASE_CFG  8'h28
`define DPS_A_OT_CFG     8'h2c
`define DPS_A_LT_CFG     8'h30
`define DPS_A_STATUS     8'h34
`define DPS_A_CTRL       8'h38
`define DPS_A_THERMAL    8'h3c
// ==========================================================
// Reset values
`define DPS_RST_ACC_LVL  8'h96
`define DPS_RST_ACC_LIM  8'h32
`define DPS_RST_RUN_LVL  8'h96
`define DPS_RST_RUN_TIME 7'h64
`define DPS_RST_BASE     14'h0258
// ==========================================================
// Decel stall defaults by class, volts
`define DPS_DEC_200V 11'h181
`define DPS_DEC_400V 11'h302
`define DPS_DEC_575V 11'h3b6
`define DPS_DEC_690V 11'h474
// ==========================================================
// Percent thresholds and codes
`define DPS_ACC_SOFT_PCT 9'h00f
`define DPS_RUN_HYST_PCT 9'h002
`define DPS_INLOSS_MIN_PCT  9'h01e
`define DPS_OUTLOSS_MIN_PCT 9'h00a
`define DPS_MFI_MOTOR2   8'h28
`define DPS_AI2_RUN_LVL  4'h7
// ==========================================================
// Overload curve, frequency in 0.1 Hz
`define DPS_F_1HZ   32'd10
`define DPS_F_6HZ   32'd60
`define DPS_F_20HZ  32'd200
`define DPS_F_60HZ  32'd600
`define DPS_P_40    32'd40
`define DPS_P_70    32'd70
`define DPS_P_83    32'd83
`define DPS_P_100   32'd100
`define DPS_OL_COLD_S   32'd330
`define DPS_OL_HOT_S    32'd210
`define DPS_OL_REF_EXC  32'd50
`define DPS_OL_COOL     25'h0000019
// ==========================================================
// Timing
`define DPS_CLK_NS     20
`define DPS_MS_NS      1000000
`define DPS_MS_PER_DS  14'h0064
`endif

// *** dps_pkg.sv ***
// Types shared by the drive protection supervisor
package dps_pkg;
  typedef enum logic [2:0] {
    DPS_MODE_VF              = 3'b000,
    DPS_MODE_VF_ENCODER      = 3'b001,
    DPS_MODE_SENSORLESS      = 3'b010,
    DPS_MODE_SENSOR_VEC      = 3'b011,
    DPS_MODE_SENSORLESS_TWO  = 3'b100
  } dps_mode_t;
  typedef enum logic [1:0] {
    DPS_RS_IDLE    = 2'b00,
    DPS_RS_REDUCE  = 2'b01,
    DPS_RS_RECOVER = 2'b10
  } dps_rs_t;
endpackage : dps_pkg

// *** dps_top.sv ***
// Drive protection supervisor: stall, overload, phase loss, torque
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "dps_defs.svh"
// ==========================================================
// Torque window detector
module dps_torq_det
  import dps_pkg::*;
#(
  parameter bit LOW = 1'b0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       ms_tick,
  input  wire logic [1:0] mode,
  input  wire logic [8:0] level,
  input  wire logic [6:0] time_ds,
  input  wire logic [8:0] value,
  input  wire logic       running,
  input  wire logic       freq_arrived,
  output logic            hit
);
  typedef struct packed {
    logic [13:0] cnt;
    logic        hit;
  } dps_tq_t;
  dps_tq_t s_r, s_nxt;
  logic armed, cond;
  always_comb
  begin
    s_nxt = s_r;
    armed = (mode == 2'd1) ? (running && freq_arrived) :
            (mode == 2'd2) ? running : 1'b0;
    cond  = armed && (LOW ? (value < level) : (value > level));
    if (!cond)
    begin
      s_nxt.cnt = '0;
      s_nxt.hit = 1'b0;
    end
    else if (s_r.cnt >= 14'(time_ds) * `DPS_MS_PER_DS)
      s_nxt.hit = 1'b1;
    else if (ms_tick)
      s_nxt.cnt = s_r.cnt + 14'h0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else if (clk_en)
      s_r <= s_nxt;
  end
  assign hit = s_r.hit;
endmodule : dps_torq_det

// ==========================================================
// Top level
module dps_top
  import dps_pkg::*;
#(
  parameter int MS_CYCLES = `DPS_MS_NS / `DPS_CLK_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [8:0]  current_pct,
  input  wire logic [8:0]  torque_pct,
  input  wire logic [10:0] dc_bus_v,
  input  wire logic [13:0] out_freq,
  input  wire logic [7:0]  ai2_level,
  input  wire logic [1:0]  volt_class,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        running,
  input  wire logic        freq_arrived,
  input  wire logic        in_loss_pin,
  input  wire logic        out_loss_pin,
  input  wire logic        reset_pin,
  input  wire logic        motor2_pin,
  output logic             output_enable,
  output logic             decel_stop_req,
  output logic             accel_rate_reduce,
  output logic             accel_hold,
  output logic             decel_hold,
  output logic             run_stall_ramp_down,
  output logic             run_stall_ramp_up,
  output logic             accel_time_sel,
  output logic             fault_contact,
  output logic             alarm,
  output logic             motor_overload_trip,
  output logic             input_phase_loss_flag,
  output logic             output_phase_loss_flag
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]  sy1, sy2, sy3, pin;
    logic [3:0]  stall_ctrl;
    logic [7:0]  acc_lvl, acc_lim, acc_lvl2, acc_lim2;
    logic [10:0] dec_lvl;
    logic        dflt_pend;
    logic [7:0]  run_lvl;
    logic [6:0]  run_time;
    logic [2:0]  ctrl_mode;
    logic [3:0]  ai2_func;
    logic [7:0]  mfi_func;
    logic [13:0] base_freq;
    logic [2:0]  ol_cfg;
    logic        ol_act;
    logic [1:0]  phase_en;
    logic [22:0] ot_cfg, lt_cfg;
    logic [15:0] ms_cnt;
    logic        ms_tick;
    dps_rs_t     rs_state;
    logic [6:0]  rs_cnt;
    logic [24:0] ol_acc;
    logic [8:0]  status;
    logic        out_en, dstop, acc_red, acc_hold, dec_hold;
    logic        rs_down, rs_up, fault, alarm;
    logic        pready, pslverr;
    logic [31:0] prdata;
  } dps_state_t;
  dps_state_t s_r, s_nxt;

  logic        ot_hit, lt_hit, vf_basis, motor2, rs_en, clr;
  logic        wr, ol_over, ol_live, in_loss_det, out_loss_det;
  logic [8:0]  tq_val, rs_lvl, acc_eff, ol_thr;
  logic [7:0]  lvl_sel, lim_sel;
  logic [31:0] scaled, f32, thr32, rd, lim32;
  logic [8:0]  w1c;

  // ==========================================================
  // Torque detectors
  assign vf_basis = (s_r.ctrl_mode == DPS_MODE_VF) ||
                    (s_r.ctrl_mode == DPS_MODE_VF_ENCODER);
  assign tq_val   = vf_basis ? current_pct : torque_pct;
  dps_torq_det #(.LOW(1'b0)) u_over (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .ms_tick      (s_r.ms_tick),
    .mode         (s_r.ot_cfg[1:0]),
    .level        (s_r.ot_cfg[12:4]),
    .time_ds      (s_r.ot_cfg[22:16]),
    .value        (tq_val),
    .running      (running),
    .freq_arrived (freq_arrived),
    .hit          (ot_hit)
  );
  dps_torq_det #(.LOW(1'b1)) u_low (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .ms_tick      (s_r.ms_tick),
    .mode         (s_r.lt_cfg[1:0]),
    .level        (s_r.lt_cfg[12:4]),
    .time_ds      (s_r.lt_cfg[22:16]),
    .value        (tq_val),
    .running      (running),
    .freq_arrived (freq_arrived),
    .hit          (lt_hit)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    wr    = psel && penable && pwrite && s_r.pready;
    // Pins: a level counts once the second and third stages agree
    s_nxt.sy1 = {motor2_pin, reset_pin, out_loss_pin, in_loss_pin};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    for (int i = 0; i < 4; i++)
      if (s_r.sy2[i] == s_r.sy3[i])
        s_nxt.pin[i] = s_r.sy3[i];
    // Millisecond time base
    s_nxt.ms_tick = (s_r.ms_cnt == 16'(MS_CYCLES - 1));
    s_nxt.ms_cnt  = s_nxt.ms_tick ? 16'h0000 : s_r.ms_cnt + 16'h0001;
    // Class default taken once after reset release
    if (s_r.dflt_pend)
    begin
      s_nxt.dflt_pend = 1'b0;
      case (volt_class)
        2'd0:    s_nxt.dec_lvl = `DPS_DEC_200V;
        2'd1:    s_nxt.dec_lvl = `DPS_DEC_400V;
        2'd2:    s_nxt.dec_lvl = `DPS_DEC_575V;
        default: s_nxt.dec_lvl = `DPS_DEC_690V;
      endcase
    end

    // Acceleration stall
    motor2  = s_r.pin[3] && (s_r.mfi_func == `DPS_MFI_MOTOR2);
    lvl_sel = motor2 ? s_r.acc_lvl2 : s_r.acc_lvl;
    lim_sel = motor2 ? s_r.acc_lim2 : s_r.acc_lim;
    acc_eff = {1'b0, lvl_sel};
    scaled  = '0;
    if (out_freq > s_r.base_freq && out_freq != 14'h0000)
    begin
      scaled = (32'(lvl_sel) * 32'(s_r.base_freq)) / 32'(out_freq);
      acc_eff = (scaled < 32'(lim_sel)) ? {1'b0, lim_sel}
                                        : scaled[8:0];
    end
    s_nxt.acc_hold = !s_r.stall_ctrl[0] && accelerating &&
                     current_pct >= acc_eff;
    s_nxt.acc_red  = !s_r.stall_ctrl[0] && accelerating &&
                     (acc_eff < `DPS_ACC_SOFT_PCT ||
                      current_pct >= acc_eff - `DPS_ACC_SOFT_PCT);

    // Deceleration stall: hold until bus drops below level
    s_nxt.dec_hold = !s_r.stall_ctrl[1] && decelerating &&
                     (dc_bus_v > s_r.dec_lvl ||
                      (s_r.dec_hold && dc_bus_v >= s_r.dec_lvl));

    // Run stall
    rs_lvl = (s_r.ai2_func == `DPS_AI2_RUN_LVL) ? {1'b0, ai2_level}
                                                : {1'b0, s_r.run_lvl};
    rs_en  = !s_r.stall_ctrl[2] && running &&
             (s_r.ctrl_mode == DPS_MODE_VF ||
              s_r.ctrl_mode == DPS_MODE_VF_ENCODER ||
              s_r.ctrl_mode == DPS_MODE_SENSORLESS_TWO);
    s_nxt.status = s_r.status;
    if (!rs_en)
    begin
      s_nxt.rs_state = DPS_RS_IDLE;
      s_nxt.rs_cnt   = '0;
    end
    else
      case (s_r.rs_state)
        DPS_RS_REDUCE:
          if ({1'b0, current_pct} + {1'b0, `DPS_RUN_HYST_PCT} <
              {1'b0, rs_lvl})
            s_nxt.rs_state = DPS_RS_RECOVER;
        DPS_RS_RECOVER:
          if (freq_arrived || current_pct > rs_lvl)
            s_nxt.rs_state = DPS_RS_IDLE;
        default:
          if (current_pct <= rs_lvl)
            s_nxt.rs_cnt = '0;
          else if (s_r.rs_cnt >= s_r.run_time)
          begin
            s_nxt.rs_state  = DPS_RS_REDUCE;
            s_nxt.rs_cnt    = '0;
            s_nxt.status[8] = 1'b1;
          end
          else if (s_r.ms_tick)
            s_nxt.rs_cnt = s_r.rs_cnt + 7'h01;
      endcase
    s_nxt.rs_down = (s_nxt.rs_state == DPS_RS_REDUCE);
    s_nxt.rs_up   = (s_nxt.rs_state == DPS_RS_RECOVER);

    // Overload threshold against output frequency
    f32 = 32'(out_freq);
    if (s_r.ol_cfg[2])
      thr32 = (f32 < `DPS_F_1HZ) ? `DPS_P_83 :
              (f32 >= `DPS_F_6HZ) ? `DPS_P_100 :
              `DPS_P_83 + (f32 - `DPS_F_1HZ) * (`DPS_P_100 - `DPS_P_83)
                / (`DPS_F_6HZ - `DPS_F_1HZ);
    else if (f32 < `DPS_F_1HZ)
      thr32 = `DPS_P_40;
    else if (f32 < `DPS_F_20HZ)
      thr32 = `DPS_P_40 + (f32 - `DPS_F_1HZ) * (`DPS_P_70 - `DPS_P_40)
              / (`DPS_F_20HZ - `DPS_F_1HZ);
    else if (f32 < `DPS_F_60HZ)
      thr32 = `DPS_P_70 + (f32 - `DPS_F_20HZ) * (`DPS_P_100 - `DPS_P_70)
              / (`DPS_F_60HZ - `DPS_F_20HZ);
    else
      thr32 = `DPS_P_100;
    ol_thr = thr32[8:0];
    // Excess of 50% accrued per ms reaches the limit in the set time
    lim32 = `DPS_OL_REF_EXC * 32'd1000 *
            (s_r.ol_cfg[1] ? `DPS_OL_HOT_S : `DPS_OL_COLD_S);
    if (!s_r.ol_cfg[0])
      s_nxt.ol_acc = '0;
    else if (s_r.ms_tick)
    begin
      if (current_pct > ol_thr)
        s_nxt.ol_acc = (32'(s_r.ol_acc) + 32'(current_pct - ol_thr)
                        >= lim32) ? lim32[24:0]
                     : s_r.ol_acc + 25'(current_pct - ol_thr);
      else
        s_nxt.ol_acc = (s_r.ol_acc > `DPS_OL_COOL)
                     ? s_r.ol_acc - `DPS_OL_COOL : '0;
    end
    ol_over = s_r.ol_cfg[0] && 32'(s_r.ol_acc) >= lim32;
    ol_live = ol_over && s_r.ol_act && current_pct > ol_thr;

    // Phase loss, suppressed at light load
    in_loss_det  = s_r.phase_en[0] && s_r.pin[0] &&
                   current_pct >= `DPS_INLOSS_MIN_PCT;
    out_loss_det = s_r.phase_en[1] && s_r.pin[1] &&
                   current_pct >= `DPS_OUTLOSS_MIN_PCT;

    // Sticky flags: clears go before every set but the run stall bit 8, so a same-cycle event wins on all other bits
    clr = s_r.pin[2] || (wr && paddr == `DPS_A_CTRL && pwdata[0]);
    w1c = (wr && paddr == `DPS_A_STATUS) ? pwdata[8:0] : '0;
    if (clr)
      s_nxt.status = s_nxt.status & 9'h1a2;
    s_nxt.status = s_nxt.status & ~(w1c & 9'h1a2);
    if (ol_over && !s_r.ol_act) s_nxt.status[0] = 1'b1;
    if (ol_live) s_nxt.status[1] = 1'b1;
    if (in_loss_det) s_nxt.status[2] = 1'b1;
    if (out_loss_det) s_nxt.status[3] = 1'b1;
    if (ot_hit && s_r.ot_cfg[3:2] != 2'd1) s_nxt.status[4] = 1'b1;
    if (ot_hit && s_r.ot_cfg[3:2] == 2'd1) s_nxt.status[5] = 1'b1;
    if (lt_hit && s_r.lt_cfg[3:2] != 2'd1) s_nxt.status[6] = 1'b1;
    if (lt_hit && s_r.lt_cfg[3:2] == 2'd1) s_nxt.status[7] = 1'b1;

    // Actions of held faults; alarm from live conditions
    s_nxt.out_en = !((s_nxt.status[0] && !s_r.ol_act) ||
                     s_nxt.status[2] || s_nxt.status[3] ||
                     (s_nxt.status[4] && s_r.ot_cfg[3:2] == 2'd2) ||
                     (s_nxt.status[6] && s_r.lt_cfg[3:2] == 2'd2));
    s_nxt.dstop  = (s_nxt.status[4] && s_r.ot_cfg[3:2] == 2'd0) ||
                   (s_nxt.status[6] && s_r.lt_cfg[3:2] == 2'd0);
    s_nxt.fault  = |{s_nxt.status[6], s_nxt.status[4],
                     s_nxt.status[3:2], s_nxt.status[0]};
    s_nxt.alarm  = ol_live || (ot_hit && s_r.ot_cfg[3:2] == 2'd1) ||
                   (lt_hit && s_r.lt_cfg[3:2] == 2'd1);

    // ==========================================================
    // APB: one wait state, write lands when pready is seen
    rd = '0;
    case (paddr)
      `DPS_A_STALL_CTRL: rd = {28'h0, s_r.stall_ctrl};
      `DPS_A_ACC_LVL:    rd = {24'h0, s_r.acc_lvl};
      `DPS_A_ACC_LIM:    rd = {24'h0, s_r.acc_lim};
      `DPS_A_ACC_LVL2:   rd = {24'h0, s_r.acc_lvl2};
      `DPS_A_ACC_LIM2:   rd = {24'h0, s_r.acc_lim2};
      `DPS_A_DEC_LVL:    rd = {21'h0, s_r.dec_lvl};
      `DPS_A_RUN_STALL:  rd = {17'h0, s_r.run_time, s_r.run_lvl};
      `DPS_A_MODE:       rd = {16'h0, s_r.mfi_func, s_r.ai2_func,
                               1'b0, s_r.ctrl_mode};
      `DPS_A_BASE_FREQ:  rd = {18'h0, s_r.base_freq};
      `DPS_A_OL_CFG:     rd = {23'h0, s_r.ol_act, 5'h0, s_r.ol_cfg};
      `DPS_A_PHASE_CFG:  rd = {30'h0, s_r.phase_en};
      `DPS_A_OT_CFG:     rd = {9'h0, s_r.ot_cfg};
      `DPS_A_LT_CFG:     rd = {9'h0, s_r.lt_cfg};
      `DPS_A_STATUS:     rd = {23'h0, s_r.status};
      `DPS_A_CTRL:       rd = '0;
      `DPS_A_THERMAL:    rd = {7'h0, s_r.ol_acc};
      default:           rd = '0;
    endcase
    s_nxt.pready  = psel && penable && !s_r.pready;
    s_nxt.prdata  = (s_nxt.pready && !pwrite) ? rd : s_r.prdata;
    s_nxt.pslverr = s_nxt.pready && (paddr[1:0] != 2'b00 ||
                                     paddr > `DPS_A_THERMAL);
    if (wr)
      case (paddr)
        `DPS_A_STALL_CTRL: s_nxt.stall_ctrl = pwdata[3:0];
        `DPS_A_ACC_LVL:    s_nxt.acc_lvl    = pwdata[7:0];
        `DPS_A_ACC_LIM:    s_nxt.acc_lim    = pwdata[7:0];
        `DPS_A_ACC_LVL2:   s_nxt.acc_lvl2   = pwdata[7:0];
        `DPS_A_ACC_LIM2:   s_nxt.acc_lim2   = pwdata[7:0];
        `DPS_A_DEC_LVL:
        begin
          s_nxt.dec_lvl   = pwdata[10:0];
          s_nxt.dflt_pend = 1'b0;
        end
        `DPS_A_RUN_STALL:
        begin
          s_nxt.run_lvl  = pwdata[7:0];
          s_nxt.run_time = pwdata[14:8];
        end
        `DPS_A_MODE:
        begin
          s_nxt.ctrl_mode = pwdata[2:0];
          s_nxt.ai2_func  = pwdata[7:4];
          s_nxt.mfi_func  = pwdata[15:8];
        end
        `DPS_A_BASE_FREQ:  s_nxt.base_freq = pwdata[13:0];
        `DPS_A_OL_CFG:
        begin
          s_nxt.ol_cfg = pwdata[2:0];
          s_nxt.ol_act = pwdata[8];
        end
        `DPS_A_PHASE_CFG:  s_nxt.phase_en = pwdata[1:0];
        `DPS_A_OT_CFG:     s_nxt.ot_cfg   = pwdata[22:0];
        `DPS_A_LT_CFG:     s_nxt.lt_cfg   = pwdata[22:0];
        default:           s_nxt.stall_ctrl = s_nxt.stall_ctrl;
      endcase
  end

  // ==========================================================
  // Registers; accumulator cleared by the power-up reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r           <= '0;
      s_r.acc_lvl   <= `DPS_RST_ACC_LVL;
      s_r.acc_lim   <= `DPS_RST_ACC_LIM;
      s_r.acc_lvl2  <= `DPS_RST_ACC_LVL;
      s_r.acc_lim2  <= `DPS_RST_ACC_LIM;
      s_r.run_lvl   <= `DPS_RST_RUN_LVL;
      s_r.run_time  <= `DPS_RST_RUN_TIME;
      s_r.base_freq <= `DPS_RST_BASE;
      s_r.dflt_pend <= 1'b1;
      s_r.out_en    <= 1'b1;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign prdata                 = s_r.prdata;
  assign pready                 = s_r.pready;
  assign pslverr                = s_r.pslverr;
  assign output_enable          = s_r.out_en;
  assign decel_stop_req         = s_r.dstop;
  assign accel_rate_reduce      = s_r.acc_red;
  assign accel_hold             = s_r.acc_hold;
  assign decel_hold             = s_r.dec_hold;
  assign run_stall_ramp_down    = s_r.rs_down;
  assign run_stall_ramp_up      = s_r.rs_up;
  assign accel_time_sel         = s_r.stall_ctrl[3];
  assign fault_contact          = s_r.fault;
  assign alarm                  = s_r.alarm;
  assign motor_overload_trip    = s_r.status[0];
  assign input_phase_loss_flag  = s_r.status[2];
  assign output_phase_loss_flag = s_r.status[3];

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence seq_quiet;
    clk_en && !clr && !wr;
  endsequence
  a_inloss_set: assert property (
    clk_en && in_loss_det |=> s_r.status[2])
    else $error("input phase loss not flagged");
  a_inloss_light: assert property (
    seq_quiet and (!s_r.status[2] && current_pct < `DPS_INLOSS_MIN_PCT)
    |=> !s_r.status[2])
    else $error("input phase loss flagged at light load");
  a_outloss_set: assert property (
    clk_en && out_loss_det |=> s_r.status[3])
    else $error("output phase loss not flagged");
  a_acc_hold_on: assert property (
    clk_en && !s_r.stall_ctrl[0] && accelerating &&
    current_pct >= acc_eff |=> s_r.acc_hold)
    else $error("acceleration not held at stall level");
  a_dec_resume: assert property (
    clk_en && s_r.dec_hold && dc_bus_v < s_r.dec_lvl |=> !s_r.dec_hold)
    else $error("deceleration not resumed");
  a_run_mode_gate: assert property (
    clk_en && s_r.ctrl_mode == DPS_MODE_SENSOR_VEC
    |=> s_r.rs_state == DPS_RS_IDLE)
    else $error("run stall active in vector mode");
  a_fault_sticky: assert property (
    s_r.status[0] ##0 seq_quiet |=> s_r.status[0])
    else $error("fault flag dropped without reset");
  a_ol_out_off: assert property (
    seq_quiet and (s_r.status[0] && !s_r.ol_act) |=> !s_r.out_en)
    else $error("output still enabled after overload trip");
endmodule : dps_top

// *** dps_top_bench.sv ***
// Self-checking bench for the drive protection supervisor
`include "dps_defs.svh"
// ==========================================================
// Bench
module dps_top_bench import dps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, clk_en = 1'h1, accelerating = 1'h0;
  logic        decelerating = 1'h0, running = 1'h0, freq_arrived = 1'h0;
  logic        in_loss_pin = 1'h0, out_loss_pin = 1'h0, reset_pin = 1'h0;
  logic        motor2_pin = 1'h0, pready, pslverr, se, output_enable;
  logic        accel_rate_reduce, accel_hold, decel_hold, accel_time_sel;
  logic        fault_contact, input_phase_loss_flag, output_phase_loss_flag;
  logic        decel_stop_req, run_stall_ramp_down, run_stall_ramp_up;
  logic        alarm, motor_overload_trip;
  logic [7:0]  paddr = 8'h00, ai2_level = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0]  current_pct = 9'h000, torque_pct = 9'h000;
  logic [10:0] dc_bus_v = 11'h000;
  logic [13:0] out_freq = 14'h0000;
  logic [1:0]  volt_class = 2'h1;
  int          err_count = 0, samples_checked = 0;

  always #10 pclk = ~pclk;

  // Short millisecond tick keeps timed counts inside the run
  dps_top #(.MS_CYCLES(10)) DUT (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .current_pct, .torque_pct, .dc_bus_v, .out_freq, .ai2_level,
    .volt_class, .accelerating, .decelerating, .running, .freq_arrived,
    .in_loss_pin, .out_loss_pin, .reset_pin, .motor2_pin, .output_enable,
    .decel_stop_req, .accel_rate_reduce, .accel_hold, .decel_hold,
    .run_stall_ramp_down, .run_stall_ramp_up, .accel_time_sel,
    .fault_contact, .alarm, .motor_overload_trip,
    .input_phase_loss_flag, .output_phase_loss_flag);
// ==========================================================
// Tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Waits on pready rather than a fixed count; bounded against hangs
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20 && pready !== 1'h1; n++)
      @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n == 20)
    begin
      err_count++;
      finish_test;
    end
  endtask : apb

  task automatic settle(input logic [8:0] c);
    current_pct <= c;
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic t_regs;
    apb(1'h0, `DPS_A_ACC_LVL, 32'h0);
    chk("acc_lvl", 32'h96, rd);
    apb(1'h0, `DPS_A_DEC_LVL, 32'h0);
    chk("dec_lvl", 32'h302, rd);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    $display("test regs done");
  endtask : t_regs

  task automatic t_accel;
    accelerating <= 1'h1;
    settle(9'h087);
    chk("reduce", 32'h1, 32'(accel_rate_reduce));
    chk("hold", 32'h0, 32'(accel_hold));
    settle(9'h086);
    chk("reduce", 32'h0, 32'(accel_rate_reduce));
    settle(9'h096);
    chk("hold", 32'h1, 32'(accel_hold));
    apb(1'h1, `DPS_A_STALL_CTRL, 32'h9);
    settle(9'h096);
    chk("hold", 32'h0, 32'(accel_hold));
    chk("time_sel", 32'h1, 32'(accel_time_sel));
    apb(1'h1, `DPS_A_STALL_CTRL, 32'h0);
    out_freq <= 14'h04b0;
    settle(9'h04b);
    chk("hold", 32'h1, 32'(accel_hold));
    accelerating <= 1'h0;
    out_freq <= 14'h0000;
    $display("test accel done");
  endtask : t_accel

  task automatic t_decel;
    decelerating <= 1'h1;
    dc_bus_v <= 11'h303;
    settle(9'h000);
    chk("dec_hold", 32'h1, 32'(decel_hold));
    dc_bus_v <= 11'h301;
    settle(9'h000);
    chk("dec_hold", 32'h0, 32'(decel_hold));
    decelerating <= 1'h0;
    $display("test decel done");
  endtask : t_decel

  task automatic t_phase;
    apb(1'h1, `DPS_A_PHASE_CFG, 32'h3);
    in_loss_pin <= 1'h1;
    settle(9'h01d);
    chk("in_loss", 32'h0, 32'(input_phase_loss_flag));
    settle(9'h01e);
    chk("in_loss", 32'h1, 32'(input_phase_loss_flag));
    chk("fault", 32'h1, 32'(fault_contact));
    chk("out_en", 32'h0, 32'(output_enable));
    in_loss_pin <= 1'h0;
    settle(9'h01e);
    chk("in_loss", 32'h1, 32'(input_phase_loss_flag));
    apb(1'h1, `DPS_A_CTRL, 32'h1);
    settle(9'h009);
    chk("in_loss", 32'h0, 32'(input_phase_loss_flag));
    chk("out_en", 32'h1, 32'(output_enable));
    out_loss_pin <= 1'h1;
    settle(9'h009);
    chk("out_loss", 32'h0, 32'(output_phase_loss_flag));
    settle(9'h00a);
    chk("out_loss", 32'h1, 32'(output_phase_loss_flag));
    out_loss_pin <= 1'h0;
    reset_pin <= 1'h1;
    settle(9'h00a);
    reset_pin <= 1'h0;
    settle(9'h000);
    chk("out_loss", 32'h0, 32'(output_phase_loss_flag));
    $display("test phase loss done");
  endtask : t_phase

  task automatic t_run;
    running <= 1'h1;
    apb(1'h1, `DPS_A_RUN_STALL, 32'h0296);
    settle(9'h097);
    repeat (40) @(posedge pclk);
    chk("rs_down", 32'h1, 32'(run_stall_ramp_down));
    settle(9'h094);
    chk("rs_down", 32'h1, 32'(run_stall_ramp_down));
    settle(9'h093);
    chk("rs_down", 32'h0, 32'(run_stall_ramp_down));
    chk("rs_up", 32'h1, 32'(run_stall_ramp_up));
    freq_arrived <= 1'h1;
    settle(9'h093);
    chk("rs_up", 32'h0, 32'(run_stall_ramp_up));
    apb(1'h1, `DPS_A_MODE, 32'h3);
    settle(9'h097);
    repeat (40) @(posedge pclk);
    chk("rs_down", 32'h0, 32'(run_stall_ramp_down));
    apb(1'h1, `DPS_A_MODE, 32'h0);
    running <= 1'h0;
    freq_arrived <= 1'h0;
    $display("test run stall done");
  endtask : t_run

  task automatic t_torque;
    running <= 1'h1;
    apb(1'h1, `DPS_A_OT_CFG, 32'h0642);
    settle(9'h065);
    chk("dstop", 32'h1, 32'(decel_stop_req));
    apb(1'h1, `DPS_A_OT_CFG, 32'h064a);
    settle(9'h065);
    chk("out_en", 32'h0, 32'(output_enable));
    apb(1'h1, `DPS_A_OT_CFG, 32'h0646);
    apb(1'h1, `DPS_A_CTRL, 32'h1);
    settle(9'h065);
    chk("dstop", 32'h0, 32'(decel_stop_req));
    chk("alarm", 32'h1, 32'(alarm));
    apb(1'h1, `DPS_A_MODE, 32'h2);
    settle(9'h065);
    chk("alarm", 32'h0, 32'(alarm));
    apb(1'h1, `DPS_A_OT_CFG, 32'h0);
    apb(1'h1, `DPS_A_LT_CFG, 32'h0c82);
    settle(9'h065);
    chk("dstop", 32'h1, 32'(decel_stop_req));
    apb(1'h1, `DPS_A_LT_CFG, 32'h0);
    apb(1'h1, `DPS_A_MODE, 32'h0);
    running <= 1'h0;
    $display("test torque done");
  endtask : t_torque

  // Trip itself takes minutes of ticks; only heating and clearing fit
  task automatic t_ol;
    apb(1'h1, `DPS_A_OL_CFG, 32'h1);
    settle(9'h096);
    repeat (40) @(posedge pclk);
    apb(1'h0, `DPS_A_THERMAL, 32'h0);
    chk("heating", 32'h1, 32'(rd != 32'h0));
    chk("ol_trip", 32'h0, 32'(motor_overload_trip));
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    apb(1'h0, `DPS_A_THERMAL, 32'h0);
    chk("thermal", 32'h0, rd);
    $display("test overload done");
  endtask : t_ol

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    t_regs;
    t_accel;
    t_decel;
    t_phase;
    t_run;
    t_torque;
    t_ol;
    finish_test;
  end
endmodule : dps_top_bench
